// file: src/ebra_ctrl.sv
// ebra_ctrl: external bus cycle sequencer with ready stretching and hold arbitration.
// assumes: i_link_clk is the bus reference clock; pins are pulled up outside while floated.
//
// Overview of operation
// - external circuit stretches a running bus cycle through the ready input.
// - ready polarity is selectable; either level may mean ready.
// - asynchronous ready passes an extra synchroniser, costing at least one wait state.
// - first ready sample comes only after the programmed access phase elapses.
// - ready sampled inactive adds one more wait state and samples again.
// - ready sampled active ends the cycle; sample points differ by mode.
// - bus is released to a hold request only with arbitration enabled.
// - a running bus cycle completes before hold acknowledge is given.
// - on release strobes go inactive, ale low, then float to pull-up.
// - bus regain request is asserted only after the bus was granted away.
// - regain starts when hold goes inactive or arbitration is disabled, requested or not.
// - on regain outputs float, then drive inactive, then acknowledge is removed.
// - the next own bus cycle starts only after the regain sequence completes.
`timescale 1ns/1ns
module ebra_ctrl #(
  parameter int ADDR_W = ebra_pkg::ADDR_W,
  parameter int DATA_W = ebra_pkg::DATA_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [ebra_pkg::LEN_W-1:0] i_acc_len,
  input wire logic i_rdy_en,
  input wire logic i_rdy_async,
  input wire logic i_rdy_pol,
  input wire logic i_arb_en,
  output logic o_busy,
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_link_clk,
  input wire logic i_ready,
  input wire logic i_hold_n,
  input wire logic [DATA_W-1:0] i_data,
  output logic o_bus_ref_clock_out,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_ale,
  output logic o_ctrl_oe,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_addr_oe,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  output logic o_bus_grant_ack_n,
  output logic o_bus_regain_request_n
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_W < 1 || ADDR_W > ebra_pkg::ADDR_W || DATA_W < 1 || DATA_W > ebra_pkg::DATA_W)
  begin : g_chk_width
    $error("bus width out of range");
  end

  // clamp a programmed access length into its legal range
  function automatic logic [5:0] clamp_len(input logic [5:0] len);
    if (len < ebra_pkg::ACC_LEN_MIN)
      return ebra_pkg::ACC_LEN_MIN;
    if (len > ebra_pkg::ACC_LEN_MAX)
      return ebra_pkg::ACC_LEN_MAX;
    return len;
  endfunction

  // ---------------------------------------------------------------
  // core side request capture
  // ---------------------------------------------------------------
  logic busy_r;
  logic req_wr_r;
  logic [ADDR_W-1:0] req_addr_r;
  logic [DATA_W-1:0] req_wdata_r;
  logic [5:0] req_len_r;
  logic req_rdy_en_r;
  logic req_async_r;
  logic req_pol_r;
  logic [DATA_W-1:0] rdata_r;
  logic done_clk;
  logic take_req;

  // fields stay frozen while busy, so the link side may read them after the toggle
  assign take_req = i_req & ~busy_r;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      busy_r <= 1'b0;
      req_wr_r <= 1'b0;
      req_addr_r <= '0;
      req_wdata_r <= '0;
      req_len_r <= ebra_pkg::ACC_LEN_MIN;
      req_rdy_en_r <= 1'b0;
      req_async_r <= 1'b0;
      req_pol_r <= 1'b1;
    end
    else if (take_req)
    begin
      busy_r <= 1'b1;
      req_wr_r <= i_wr;
      req_addr_r <= i_addr;
      req_wdata_r <= i_wdata;
      req_len_r <= clamp_len(i_acc_len);
      req_rdy_en_r <= i_rdy_en;
      req_async_r <= i_rdy_async;
      req_pol_r <= i_rdy_pol;
    end
    else if (done_clk)
      busy_r <= 1'b0;
  end

  logic [DATA_W-1:0] link_rdata_r;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rdata_r <= '0;
    else if (done_clk)
      rdata_r <= link_rdata_r;
  end

  assign o_busy = busy_r;
  assign o_done = done_clk;
  assign o_rdata = rdata_r;

  // ---------------------------------------------------------------
  // link domain reset and crossings
  // ---------------------------------------------------------------
  logic lrst_s1_r;
  logic lrst_r;
  logic start_link;
  logic done_link;
  logic hold_n_q;
  logic rdy_async_q;
  logic arb_en_q;
  logic rdy_sync_r;

  always_ff @(posedge i_link_clk)
  begin
    lrst_s1_r <= i_rst;
    lrst_r <= lrst_s1_r;
  end

  ebra_pulse_xfer u_req_xfer (
    .i_src_clk(i_clk), .i_src_rst(i_rst), .i_src_pulse(take_req),
    .i_dst_clk(i_link_clk), .i_dst_rst(lrst_r), .o_dst_pulse(start_link)
  );

  ebra_pulse_xfer u_done_xfer (
    .i_src_clk(i_link_clk), .i_src_rst(lrst_r), .i_src_pulse(done_link),
    .i_dst_clk(i_clk), .i_dst_rst(i_rst), .o_dst_pulse(done_clk)
  );

  ebra_sync #(.RST_VAL(ebra_pkg::HOLD_IDLE_N)) u_hold_sync (
    .i_clk(i_link_clk), .i_rst(lrst_r), .i_d(i_hold_n), .o_q(hold_n_q)
  );

  ebra_sync #(.RST_VAL(ebra_pkg::READY_RST)) u_rdy_sync (
    .i_clk(i_link_clk), .i_rst(lrst_r), .i_d(i_ready), .o_q(rdy_async_q)
  );

  ebra_sync #(.RST_VAL(1'b0)) u_arb_sync (
    .i_clk(i_link_clk), .i_rst(lrst_r), .i_d(i_arb_en), .o_q(arb_en_q)
  );

  // synchronous ready is already in the bus clock domain: one sampling flop only
  always_ff @(posedge i_link_clk)
  begin
    if (lrst_r)
      rdy_sync_r <= ebra_pkg::READY_RST;
    else
      rdy_sync_r <= i_ready;
  end

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  ebra_pkg::ebra_state_t state_r;
  ebra_pkg::ebra_state_t state_nxt;
  logic pend_r;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic rdy_level;
  logic rdy_ok;
  logic hold_req;
  logic acc_last;
  logic in_strobe;
  logic floated;

  assign rdy_level = req_async_r ? rdy_async_q : rdy_sync_r;
  assign rdy_ok = (rdy_level == req_pol_r);
  assign hold_req = arb_en_q & ~hold_n_q;
  assign acc_last = (cnt_r == ebra_pkg::ACC_LEN_MIN);
  assign done_link = (state_r == ebra_pkg::ST_END);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ebra_pkg::ST_IDLE:
      begin
        // hold is weighed only here and in the granted state, between cycles
        if (hold_req)
          state_nxt = ebra_pkg::ST_REL;
        else if (pend_r)
          state_nxt = ebra_pkg::ST_ADDR;
      end
      ebra_pkg::ST_ADDR:
      begin
        state_nxt = ebra_pkg::ST_ACC;
        cnt_nxt = req_len_r;
      end
      ebra_pkg::ST_ACC:
      begin
        if (acc_last)
          state_nxt = req_rdy_en_r ? ebra_pkg::ST_RDY : ebra_pkg::ST_END;
        else
          cnt_nxt = cnt_r - 6'h01;
      end
      ebra_pkg::ST_RDY:
      begin
        // each inactive sample is one more ready controlled wait phase
        if (rdy_ok)
          state_nxt = ebra_pkg::ST_END;
      end
      ebra_pkg::ST_END: state_nxt = ebra_pkg::ST_IDLE;
      ebra_pkg::ST_REL: state_nxt = ebra_pkg::ST_GNT;
      ebra_pkg::ST_GNT:
      begin
        if (hold_n_q | ~arb_en_q)
          state_nxt = ebra_pkg::ST_RGN1;
      end
      ebra_pkg::ST_RGN1: state_nxt = ebra_pkg::ST_RGN2;
      ebra_pkg::ST_RGN2: state_nxt = ebra_pkg::ST_IDLE;
      default: state_nxt = ebra_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_link_clk)
  begin
    if (lrst_r)
    begin
      state_r <= ebra_pkg::ST_IDLE;
      cnt_r <= ebra_pkg::ACC_LEN_MIN;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // a request that arrives while granted is kept and raises the regain request
  always_ff @(posedge i_link_clk)
  begin
    if (lrst_r)
      pend_r <= 1'b0;
    else if (start_link)
      pend_r <= 1'b1;
    else if (state_r == ebra_pkg::ST_ADDR)
      pend_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // pin outputs, registered from the next state
  // ---------------------------------------------------------------
  logic rd_n_r;
  logic wr_n_r;
  logic ale_r;
  logic ctrl_oe_r;
  logic addr_oe_r;
  logic data_oe_r;
  logic ack_n_r;
  logic bus_regain_request_n_n_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic ack_nxt;
  logic bus_regain_request_n_nxt;

  assign in_strobe = (state_nxt == ebra_pkg::ST_ACC) | (state_nxt == ebra_pkg::ST_RDY);
  assign floated = (state_nxt == ebra_pkg::ST_GNT) | (state_nxt == ebra_pkg::ST_RGN1);
  assign ack_nxt = (state_nxt == ebra_pkg::ST_GNT) | (state_nxt == ebra_pkg::ST_RGN1)
                 | (state_nxt == ebra_pkg::ST_RGN2);
  assign bus_regain_request_n_nxt = (state_nxt == ebra_pkg::ST_GNT) & (pend_r | start_link);

  always_ff @(posedge i_link_clk)
  begin
    if (lrst_r)
    begin
      rd_n_r <= ebra_pkg::STROBE_OFF_N;
      wr_n_r <= ebra_pkg::STROBE_OFF_N;
      ale_r <= ebra_pkg::ALE_OFF;
      ctrl_oe_r <= 1'b1;
      addr_oe_r <= 1'b1;
      data_oe_r <= 1'b0;
      ack_n_r <= 1'b1;
      bus_regain_request_n_n_r <= 1'b1;
    end
    else
    begin
      // strobes inactive and ale low in the release and regain edges
      rd_n_r <= ~(in_strobe & ~req_wr_r);
      wr_n_r <= ~(in_strobe & req_wr_r);
      ale_r <= (state_nxt == ebra_pkg::ST_ADDR);
      ctrl_oe_r <= ~floated;
      addr_oe_r <= ~floated;
      data_oe_r <= req_wr_r & (in_strobe | (state_nxt == ebra_pkg::ST_END));
      ack_n_r <= ~ack_nxt;
      bus_regain_request_n_n_r <= ~bus_regain_request_n_nxt;
    end
  end

  always_ff @(posedge i_link_clk)
  begin
    if (lrst_r)
    begin
      addr_r <= '0;
      data_r <= '0;
    end
    else if (state_nxt == ebra_pkg::ST_ADDR)
    begin
      addr_r <= req_addr_r;
      data_r <= req_wdata_r;
    end
  end

  // read data taken on the edge that raises the strobe
  always_ff @(posedge i_link_clk)
  begin
    if (lrst_r)
      link_rdata_r <= '0;
    else if ((state_nxt == ebra_pkg::ST_END) & ~req_wr_r & (state_r != ebra_pkg::ST_END))
      link_rdata_r <= i_data;
  end

  // the bus reference clock is the link clock itself, forwarded to the pin
  assign o_bus_ref_clock_out = i_link_clk;
  assign o_rd_n = rd_n_r;
  assign o_wr_n = wr_n_r;
  assign o_ale = ale_r;
  assign o_ctrl_oe = ctrl_oe_r;
  assign o_addr = addr_r;
  assign o_addr_oe = addr_oe_r;
  assign o_data = data_r;
  assign o_data_oe = data_oe_r;
  assign o_bus_grant_ack_n = ack_n_r;
  assign o_bus_regain_request_n = bus_regain_request_n_n_r;

endmodule

// file: src/ebra_pkg.sv
// ebra_pkg: constants and state encoding for the external bus ready and arbitration control.
// assumes: only referenced as ebra_pkg::name, never imported.
package ebra_pkg;

  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int LEN_W = 6;

  // ---------------------------------------------------------------
  // phase lengths in bus reference clock periods
  // ---------------------------------------------------------------
  localparam logic [5:0] ACC_LEN_MIN = 6'h01;
  localparam logic [5:0] ACC_LEN_MAX = 6'h20;

  // ---------------------------------------------------------------
  // synchroniser and reset values
  // ---------------------------------------------------------------
  localparam int PIN_SYNC_STAGES = 3;
  localparam logic HOLD_IDLE_N = 1'b1;
  localparam logic READY_RST = 1'b0;
  localparam logic STROBE_OFF_N = 1'b1;
  localparam logic ALE_OFF = 1'b0;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // ---------------------------------------------------------------
  // bus sequencer states, gray coded in listed order; ACC to END, END to IDLE, IDLE to REL and RGN2 to IDLE change more than one bit
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACC = 4'h3,
    ST_RDY = 4'h2,
    ST_END = 4'h6,
    ST_REL = 4'h7,
    ST_GNT = 4'h5,
    ST_RGN1 = 4'h4,
    ST_RGN2 = 4'hc
  } ebra_state_t;

endpackage

// file: src/ebra_pulse_xfer.sv
// ebra_pulse_xfer: carries a one cycle event between clock domains by a toggle.
// assumes: events in the source are spaced wider than three destination cycles.
`timescale 1ns/1ns
module ebra_pulse_xfer (
  input wire logic i_src_clk,
  input wire logic i_src_rst,
  input wire logic i_src_pulse,
  input wire logic i_dst_clk,
  input wire logic i_dst_rst,
  output logic o_dst_pulse
);

  logic tog_r;
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ---------------------------------------------------------------
  // source toggle
  // ---------------------------------------------------------------
  always_ff @(posedge i_src_clk)
  begin
    if (i_src_rst)
    begin
      tog_r <= 1'b0;
    end
    else if (i_src_pulse)
    begin
      tog_r <= ~tog_r;
    end
  end

  // ---------------------------------------------------------------
  // destination sync and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge i_dst_clk)
  begin
    if (i_dst_rst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= tog_r;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign o_dst_pulse = s2_r ^ s3_r;

endmodule

// file: src/ebra_sync.sv
// ebra_sync: three flop level synchroniser with agreement filter for pin inputs.
// assumes: i_rst is synchronous to i_clk; the input may change at any time.
`timescale 1ns/1ns
module ebra_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_d,
  output logic o_q
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;

  // ---------------------------------------------------------------
  // sync chain
  // ---------------------------------------------------------------
  // first stage is read only by the second; the filter compares stages two and three
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q_r <= RST_VAL;
    end
    else
    begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
      begin
        q_r <= s3_r;
      end
    end
  end

  assign o_q = q_r;

endmodule

// file: test/ebra_ctrl_props.sv
// ebra_props: link-side checks of strobes, grant and regain handshake of ebra_ctrl.
// assumes: bound into ebra_ctrl; i_rst spans several link periods.
`timescale 1ns/1ns
module ebra_props (
  input wire logic i_link_clk,
  input wire logic i_rst,
  input wire logic i_arb_en,
  input wire logic i_hold_n,
  input wire logic i_ready,
  input wire logic i_rdy_pol,
  input wire logic i_rdy_en,
  input wire logic i_rdy_async,
  input wire logic o_rd_n,
  input wire logic o_wr_n,
  input wire logic o_ale,
  input wire logic o_ctrl_oe,
  input wire logic o_addr_oe,
  input wire logic o_data_oe,
  input wire logic o_bus_grant_ack_n,
  input wire logic o_bus_regain_request_n
);
  default clocking @(posedge i_link_clk); endclocking
  default disable iff (i_rst);
  wire logic strb_n = o_rd_n & o_wr_n;
  wire logic rdy_on = (i_ready == i_rdy_pol);
  wire logic rel_ok = strb_n & ~o_ale & o_ctrl_oe & o_bus_grant_ack_n;

  // ---------------------------------------------------------------
  // hand-over of the bus
  // ---------------------------------------------------------------
  chk_float_on_grant: assert property ($fell(o_bus_grant_ack_n) |->
    !o_ctrl_oe && !o_addr_oe && !o_data_oe) else $error("outputs driven at grant");
  chk_drive_then_float: assert property ($fell(o_ctrl_oe) |-> $past(rel_ok))
    else $error("controls floated without inactive drive");
  chk_regain_order: assert property ($rose(o_ctrl_oe) |->
    strb_n && !o_ale && !o_bus_grant_ack_n ##1 o_bus_grant_ack_n)
    else $error("regain order wrong");
  chk_bus_regain_request_n_granted: assert property (!o_bus_regain_request_n |->
    !o_bus_grant_ack_n && !o_ctrl_oe) else $error("regain request while owning bus");
  chk_quiet_granted: assert property (!o_bus_grant_ack_n |-> strb_n && !o_ale)
    else $error("bus cycle while granted");
  chk_ale_after_ack: assert property ($rose(o_ale) |->
    $past(o_bus_grant_ack_n) && o_ctrl_oe ##1 !o_ale) else $error("address phase misplaced");
  chk_no_early_regain: assert property ((!i_hold_n && i_arb_en) [*6] ##0 !o_ctrl_oe
    |=> !o_ctrl_oe) else $error("regain while hold still low");
  chk_regain_bound: assert property ($rose(i_hold_n) && !o_bus_grant_ack_n |->
    ##[1:12] o_bus_grant_ack_n) else $error("bus not regained");
  chk_arb_off: assert property (!i_arb_en [*8] ##1 !i_arb_en |-> o_bus_grant_ack_n)
    else $error("grant with arbitration off");

  // ---------------------------------------------------------------
  // ready stretching
  // ---------------------------------------------------------------
  chk_sync_ready_gate: assert property ($rose(strb_n) && i_rdy_en && !i_rdy_async |->
    $past(rdy_on, 2) || $past(rdy_on, 3) || $past(rdy_on, 4))
    else $error("cycle ended without ready");

  cover property (!o_bus_grant_ack_n && !o_bus_regain_request_n);
  cover property ($rose(strb_n) && i_rdy_async);
  cover property (!strb_n && i_rdy_en && !rdy_on);
endmodule

bind ebra_ctrl ebra_props ebra_props_i (.i_link_clk, .i_rst, .i_arb_en, .i_hold_n, .i_ready,
  .i_rdy_pol, .i_rdy_en, .i_rdy_async, .o_rd_n, .o_wr_n, .o_ale, .o_ctrl_oe, .o_addr_oe,
  .o_data_oe, .o_bus_grant_ack_n, .o_bus_regain_request_n);

// file: test/ebra_periph.sv
// ebra_periph: external memory model answering with ready after a set delay.
// assumes: strobes arrive already resolved against their pull-ups.
`timescale 1ns/1ns
module ebra_periph (
  input wire logic i_clk,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_rdy_pol,
  input wire logic [5:0] i_rdy_dly,
  input wire logic [15:0] i_rdata,
  input wire logic [15:0] i_wdata,
  output logic o_ready = 1'b0,
  output logic [15:0] o_data,
  output logic [15:0] o_last_wr = 16'h0000
);
  logic [5:0] cnt_r = 6'h00;

  // memory drives read data while the strobe is low, so the closing edge sees it;
  // released data lines show the inverse so a stale sample never matches
  assign o_data = i_rd_n ? ~i_rdata : i_rdata;

  always @(posedge i_clk)
  begin
    if (i_rd_n & i_wr_n)
    begin
      cnt_r <= 6'h00;
      o_ready <= ~i_rdy_pol;
    end
    else
    begin
      cnt_r <= cnt_r + 6'h01;
      if (cnt_r >= i_rdy_dly)
        o_ready <= i_rdy_pol;
    end
    if (!i_wr_n)
      o_last_wr <= i_wdata;
  end
endmodule

// file: test/tb.sv
// tb: drives ebra_ctrl against the memory model and a hold-requesting master.
// assumes: core clock 10 ns, link clock 80 ns free-running with its own phase.
`timescale 1ns/1ns
module tb;
  logic i_clk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req = 1'b0;
  logic i_wr = 1'b0;
  logic [23:0] i_addr = 24'h000000;
  logic [15:0] i_wdata = 16'h0000;
  logic [5:0] i_acc_len = 6'h01;
  logic i_rdy_en = 1'b0;
  logic i_rdy_async = 1'b0;
  logic i_rdy_pol = 1'b1;
  logic i_arb_en = 1'b0;
  logic i_hold_n = 1'b1;
  logic [5:0] rdy_dly = 6'h00;
  logic [15:0] rd_pat = 16'h0000;
  logic i_ready, o_busy, o_done, o_bus_ref_clock_out, o_rd_n, o_wr_n, o_ale, o_ctrl_oe;
  logic o_addr_oe, o_data_oe, o_bus_grant_ack_n, o_bus_regain_request_n;
  logic [15:0] i_data, o_rdata, o_data, last_wr;
  logic [23:0] o_addr, addr_seen;
  logic ack_lo_seen = 1'b0;
  logic ack_at_done = 1'b0;
  int num_errors = 0, samples_checked = 0, cycles = 0, done_cnt = 0, low_cnt = 0, last_len = 0;
  // floated strobes read as their pull-up level
  wire logic rd_pin = o_ctrl_oe ? o_rd_n : 1'b1;
  wire logic wr_pin = o_ctrl_oe ? o_wr_n : 1'b1;

  ebra_ctrl ebra_ctrl_i (.i_clk, .i_rst, .i_req, .i_wr, .i_addr, .i_wdata, .i_acc_len,
    .i_rdy_en, .i_rdy_async, .i_rdy_pol, .i_arb_en, .o_busy, .o_done, .o_rdata, .i_link_clk,
    .i_ready, .i_hold_n, .i_data, .o_bus_ref_clock_out, .o_rd_n, .o_wr_n, .o_ale, .o_ctrl_oe,
    .o_addr, .o_addr_oe, .o_data, .o_data_oe, .o_bus_grant_ack_n, .o_bus_regain_request_n);
  ebra_periph ebra_periph_i (.i_clk(i_link_clk), .i_rd_n(rd_pin), .i_wr_n(wr_pin), .i_rdy_pol,
    .i_rdy_dly(rdy_dly), .i_rdata(rd_pat), .i_wdata(o_data), .o_ready(i_ready),
    .o_data(i_data), .o_last_wr(last_wr));

  // ---------------------------------------------------------------
  // clocks and monitors
  // ---------------------------------------------------------------
  always #5 i_clk = ~i_clk;
  initial #3 forever #40 i_link_clk = ~i_link_clk;

  always @(posedge i_link_clk)
  begin
    if (!(rd_pin && wr_pin))
      low_cnt <= low_cnt + 1;
    else if (low_cnt != 0)
    begin
      last_len <= low_cnt;
      low_cnt <= 0;
    end
    if (o_ale)
      addr_seen <= o_addr;
    if (!o_bus_grant_ack_n)
      ack_lo_seen <= 1'b1;
  end

  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (o_done === 1'b1)
    begin
      done_cnt <= done_cnt + 1;
      ack_at_done <= o_bus_grant_ack_n;
    end
    if (cycles == 40000)
    begin
      num_errors++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // cfg packs ready enable, async, polarity
  task automatic start(input logic wr, input logic [23:0] a, input logic [15:0] d,
    input logic [5:0] len, input logic [2:0] cfg);
    @(negedge i_clk);
    {i_rdy_en, i_rdy_async, i_rdy_pol} = cfg;
    i_wr = wr;
    i_addr = a;
    i_wdata = d;
    i_acc_len = len;
    i_req = 1'b1;
    @(negedge i_clk);
    i_req = 1'b0;
    check(o_busy, 1'b1);
  endtask

  task automatic wait_done();
    int n;
    n = done_cnt;
    repeat (3000) if (done_cnt == n) @(negedge i_clk);
    check(done_cnt, n + 1);
    repeat (3) @(negedge i_link_clk);
  endtask

  task automatic run(input logic wr, input logic [23:0] a, input logic [15:0] d,
    input logic [5:0] len, input logic [2:0] cfg, input logic [5:0] dly);
    rdy_dly = dly;
    start(wr, a, d, len, cfg);
    wait_done();
  endtask

  task automatic wait_ack(input logic v);
    repeat (20) if (o_bus_grant_ack_n !== v) @(negedge i_link_clk);
    check(o_bus_grant_ack_n, v);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_plain();
    run(1'b1, 24'h00a5c3, 16'h1234, 6'h03, 3'b000, 6'h00);
    check(last_len, 3);
    check(last_wr, 16'h1234);
    check(addr_seen, 24'h00a5c3);
    rd_pat = 16'hbeef;
    run(1'b0, 24'hfffffe, 16'h0000, 6'h00, 3'b000, 6'h00);
    check(last_len, 1);
    check(o_rdata, 16'hbeef);
    run(1'b0, 24'h000001, 16'h0000, 6'h20, 3'b000, 6'h00);
    check(last_len, 32);
    // just past a falling link edge: the forwarded reference clock must read low
    #1 check(o_bus_ref_clock_out, 1'b0);
  endtask

  task automatic t_ready();
    int ls, l6, l7;
    run(1'b0, 24'h000100, 16'h0000, 6'h01, 3'b101, 6'h00);
    ls = last_len;
    check(ls >= 1, 1'b1);
    run(1'b0, 24'h000101, 16'h0000, 6'h01, 3'b101, 6'h06);
    l6 = last_len;
    check(l6 >= 8, 1'b1);
    run(1'b0, 24'h000102, 16'h0000, 6'h01, 3'b101, 6'h07);
    l7 = last_len;
    check(l7, l6 + 1);
    rd_pat = 16'h5a0f;
    run(1'b0, 24'h000103, 16'h0000, 6'h01, 3'b111, 6'h06);
    check(last_len > l6, 1'b1);
    check(o_rdata, 16'h5a0f);
    run(1'b0, 24'h000104, 16'h0000, 6'h01, 3'b100, 6'h06);
    check(last_len, l6);
  endtask

  task automatic t_arb_off();
    @(negedge i_clk);
    i_hold_n = 1'b0;
    ack_lo_seen = 1'b0;
    run(1'b1, 24'h000200, 16'h7777, 6'h02, 3'b000, 6'h00);
    repeat (30) @(negedge i_link_clk);
    check(ack_lo_seen, 1'b0);
    @(negedge i_clk);
    i_hold_n = 1'b1;
  endtask

  task automatic t_grant();
    int n;
    i_arb_en = 1'b1;
    rdy_dly = 6'h0a;
    start(1'b0, 24'h000300, 16'h0000, 6'h02, 3'b101);
    repeat (2) @(negedge i_link_clk);
    @(negedge i_clk);
    i_hold_n = 1'b0;
    wait_done();
    check(ack_at_done, 1'b1);
    wait_ack(1'b0);
    check({o_ctrl_oe, o_addr_oe, o_data_oe}, 3'b000);
    check(o_bus_regain_request_n, 1'b1);
    n = done_cnt;
    start(1'b1, 24'h000301, 16'hc0de, 6'h01, 3'b000);
    repeat (20) @(negedge i_link_clk);
    check(o_bus_regain_request_n, 1'b0);
    check(done_cnt, n);
    check(o_bus_grant_ack_n, 1'b0);
    @(negedge i_clk);
    i_hold_n = 1'b1;
    wait_done();
    check(ack_at_done, 1'b1);
    check(last_wr, 16'hc0de);
    @(negedge i_clk);
    i_hold_n = 1'b0;
    wait_ack(1'b0);
    check(o_bus_regain_request_n, 1'b1);
    @(negedge i_clk);
    i_hold_n = 1'b1;
    wait_ack(1'b1);
  endtask

  initial
  begin
    // reset spans several link periods so the link side sees it
    repeat (40) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (40) @(negedge i_clk);
    t_plain();
    t_ready();
    t_arb_off();
    t_grant();
    complete_run();
  end
endmodule
